// ### design/reia_pkg.sv
// Package of constants and types for the radio event interrupt aggregator.
`default_nettype none
package reia_pkg;

  localparam int unsigned REIA_SUB_COUNT = 8;
  localparam int unsigned REIA_DIAG_WIDTH = 8;
  localparam int unsigned REIA_LINE_COUNT = 9;

  // Bit positions of the link-layer sub-sources.
  localparam int unsigned REIA_FINE_BIT = 0;
  localparam int unsigned REIA_GROSS_BIT = 1;
  localparam int unsigned REIA_TICK_BIT = 2;
  localparam int unsigned REIA_SLEEP_BIT = 3;
  localparam int unsigned REIA_RECEIVE_BIT = 4;
  localparam int unsigned REIA_EVENT_BIT = 5;
  localparam int unsigned REIA_CIPHER_BIT = 6;
  localparam int unsigned REIA_SOFT_BIT = 7;

  // Processor interrupt line numbers.
  localparam int unsigned REIA_LINE_RADIO = 1;
  localparam int unsigned REIA_LINE_SERIAL_ONE = 2;
  localparam int unsigned REIA_LINE_SERIAL_TWO = 3;
  localparam int unsigned REIA_LINE_TWO_WIRE = 4;
  localparam int unsigned REIA_LINE_SYNC_SERIAL = 5;
  localparam int unsigned REIA_LINE_CONVERTER = 6;
  localparam int unsigned REIA_LINE_KEY_SCANNER = 7;
  localparam int unsigned REIA_LINE_DIAG = 8;

  // Base time reference and its derived tick counts.
  localparam int unsigned REIA_CLK_FREQ_HZ = 125000000;
  localparam int unsigned REIA_BASE_TIME_US = 625;
  localparam int unsigned REIA_BASE_CYCLES = REIA_CLK_FREQ_HZ / 1000000 * REIA_BASE_TIME_US;
  localparam int unsigned REIA_GROSS_UNITS = 16;
  localparam int unsigned REIA_TIMER_WIDTH = 16;

  localparam logic [REIA_SUB_COUNT-1:0] REIA_PENDING_RESET = 8'h00;
  localparam logic [REIA_SUB_COUNT-1:0] REIA_ENABLE_RESET = 8'h00;
  localparam logic [REIA_DIAG_WIDTH-1:0] REIA_DIAG_SELECT_RESET = 8'h00;

  typedef enum logic [1:0] {
    REIA_ST_SLEEP = 2'b01,
    REIA_ST_ACTIVE = 2'b10
  } reia_mode_t;

  // Completion pulses from the link-layer engines.
  typedef struct packed {
    logic packet_received;
    logic event_finished;
    logic cipher_block_done;
    logic cipher_ccm_done;
    logic software_request;
  } reia_engine_events_t;

  // Loads of the target timers, fine in base time units, gross in 16-unit steps.
  typedef struct packed {
    logic fine_load;
    logic [REIA_TIMER_WIDTH-1:0] fine_units;
    logic gross_load;
    logic [REIA_TIMER_WIDTH-1:0] gross_units;
  } reia_timer_cmd_t;

  // Peripheral interrupt levels, lines 2 to 7.
  typedef struct packed {
    logic serial_port_one_irq;
    logic serial_port_two_irq;
    logic two_wire_bus_irq;
    logic sync_serial_irq;
    logic converter_irq;
    logic key_scanner_irq;
  } reia_periph_irq_t;

endpackage
`default_nettype wire

// ### design/reia_target_timer.sv
// Down-counting target timer that expires after a loaded number of time units.
`default_nettype none
module reia_target_timer
  import reia_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic unit_tick,
  input wire logic load,
  input wire logic [REIA_TIMER_WIDTH-1:0] units,
  output logic expired
);

  logic [REIA_TIMER_WIDTH-1:0] remaining;
  logic armed;
  wire last_unit = armed && unit_tick && (remaining == 16'h0001);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      remaining <= '0;
      armed <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= last_unit;
      if (load) begin
        remaining <= units;
        armed <= (units != 16'h0000);
      end else if (armed && unit_tick) begin
        remaining <= remaining - 16'h0001;
        armed <= !last_unit;
      end
    end
  end

endmodule
`default_nettype wire

// ### design/reia_aggregator.sv
// Top of the radio event interrupt aggregator.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Function
// - Fine target timer interrupt fires on expiry; counts in 625 us units.
// - Gross target timer interrupt fires on expiry; counts in 16 x 625 us units.
// - Base-time tick interrupt every 625 us, only while active, never in sleep.
// - End-of-sleep interrupt when the radio logic leaves sleep.
// - Receive interrupt once at the end of every received packet.
// - Event-end interrupt when an advertising, scanning or connection event ends.
// - Cipher interrupt when block cipher and/or CCM processing completes.
// - Software-triggered interrupt for each software request.
// - Line 8 shows diagnostic events chosen by a select input; debug only.
// - All link-layer sub-sources combine onto general radio line 1.
module reia_aggregator
  import reia_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sleep_request,
  input wire logic wake_request,
  input wire reia_pkg::reia_engine_events_t engine_events,
  input wire reia_pkg::reia_timer_cmd_t timer_cmd,
  input wire logic [REIA_SUB_COUNT-1:0] sub_enable,
  input wire logic [REIA_SUB_COUNT-1:0] pending_clear,
  input wire reia_pkg::reia_periph_irq_t periph_irq,
  input wire logic [REIA_DIAG_WIDTH-1:0] diag_events,
  input wire logic [REIA_DIAG_WIDTH-1:0] diagnostic_event_select,
  output logic [REIA_SUB_COUNT-1:0] sub_pending,
  output logic radio_active,
  output logic [REIA_LINE_COUNT-1:0] nvic_irq
);
  import reia_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Sleep and active mode.

  reia_mode_t mode;
  reia_mode_t next_mode;
  logic sleep_exit;

  always_comb begin
    next_mode = mode;
    unique case (mode)
      REIA_ST_SLEEP: begin
        if (wake_request) begin
          next_mode = REIA_ST_ACTIVE;
        end
      end
      REIA_ST_ACTIVE: begin
        if (sleep_request) begin
          next_mode = REIA_ST_SLEEP;
        end
      end
      default: begin
        next_mode = REIA_ST_ACTIVE;
      end
    endcase
  end

  wire leaving_sleep = (mode == REIA_ST_SLEEP) && (next_mode == REIA_ST_ACTIVE);
  wire is_active = (mode == REIA_ST_ACTIVE);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode <= REIA_ST_ACTIVE;
      sleep_exit <= 1'b0;
    end else begin
      mode <= next_mode;
      sleep_exit <= leaving_sleep;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Base time reference dividers.

  logic [16:0] base_count;
  logic [3:0] gross_count;
  logic base_tick;
  wire base_wrap = (base_count == 17'(REIA_BASE_CYCLES - 1));
  wire gross_wrap = base_wrap && (gross_count == 4'(REIA_GROSS_UNITS - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      base_count <= '0;
      gross_count <= '0;
      base_tick <= 1'b0;
    end else begin
      base_count <= base_wrap ? 17'h00000 : base_count + 17'h00001;
      if (base_wrap) begin
        gross_count <= gross_count + 4'h1;
      end
      base_tick <= base_wrap && is_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Target timers.

  logic fine_expired;
  logic gross_expired;

  reia_target_timer u_fine_timer (
    .clk(clk),
    .reset_n(reset_n),
    .unit_tick(base_wrap),
    .load(timer_cmd.fine_load),
    .units(timer_cmd.fine_units),
    .expired(fine_expired)
  );

  reia_target_timer u_gross_timer (
    .clk(clk),
    .reset_n(reset_n),
    .unit_tick(gross_wrap),
    .load(timer_cmd.gross_load),
    .units(timer_cmd.gross_units),
    .expired(gross_expired)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky pending bits; a set in the clear cycle wins.

  logic [REIA_SUB_COUNT-1:0] sub_set;
  assign sub_set[REIA_FINE_BIT] = fine_expired;
  assign sub_set[REIA_GROSS_BIT] = gross_expired;
  assign sub_set[REIA_TICK_BIT] = base_tick;
  assign sub_set[REIA_SLEEP_BIT] = sleep_exit;
  assign sub_set[REIA_RECEIVE_BIT] = engine_events.packet_received;
  assign sub_set[REIA_EVENT_BIT] = engine_events.event_finished;
  assign sub_set[REIA_CIPHER_BIT] = engine_events.cipher_block_done | engine_events.cipher_ccm_done;
  assign sub_set[REIA_SOFT_BIT] = engine_events.software_request;

  wire [REIA_SUB_COUNT-1:0] next_pending = sub_set | (sub_pending & ~pending_clear);
  wire radio_any = |(next_pending & sub_enable);
  wire diag_any = |(diag_events & diagnostic_event_select);

  ////////////////////////////////////////////////////////////////////////////////
  // Processor interrupt lines.

  wire [REIA_LINE_COUNT-1:0] next_lines = {
    diag_any,
    periph_irq.key_scanner_irq,
    periph_irq.converter_irq,
    periph_irq.sync_serial_irq,
    periph_irq.two_wire_bus_irq,
    periph_irq.serial_port_two_irq,
    periph_irq.serial_port_one_irq,
    radio_any,
    1'b0
  };

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sub_pending <= REIA_PENDING_RESET;
      nvic_irq <= '0;
      radio_active <= 1'b1;
    end else begin
      sub_pending <= next_pending;
      nvic_irq <= next_lines;
      radio_active <= (next_mode == REIA_ST_ACTIVE);
    end
  end

endmodule
`default_nettype wire

// ### dv/reia_asserts.sv
// Assertion checker for the radio event interrupt aggregator.
`default_nettype none
module reia_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire reia_pkg::reia_engine_events_t engine_events,
  input wire logic [reia_pkg::REIA_SUB_COUNT-1:0] sub_enable,
  input wire logic [reia_pkg::REIA_SUB_COUNT-1:0] pending_clear,
  input wire reia_pkg::reia_periph_irq_t periph_irq,
  input wire logic [reia_pkg::REIA_DIAG_WIDTH-1:0] diag_events,
  input wire logic [reia_pkg::REIA_DIAG_WIDTH-1:0] diagnostic_event_select,
  input wire logic [reia_pkg::REIA_SUB_COUNT-1:0] sub_pending,
  input wire logic radio_active,
  input wire logic [reia_pkg::REIA_LINE_COUNT-1:0] nvic_irq
);
  import reia_pkg::*;
  logic [5:0] periph_lines;
  assign periph_lines = {<<{periph_irq}};
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_asleep;
    !radio_active [*3];
  endsequence
  sequence s_woken;
    $rose(radio_active);
  endsequence
  a_rx_sets:
    assert property (engine_events.packet_received |=> sub_pending[REIA_RECEIVE_BIT]) else $error("rx not set");
  a_event_sets:
    assert property (engine_events.event_finished |=> sub_pending[REIA_EVENT_BIT]) else $error("event not set");
  a_cipher_sets:
    assert property (engine_events.cipher_block_done || engine_events.cipher_ccm_done |=> sub_pending[6])
      else $error("cipher not set");
  a_soft_sets:
    assert property (engine_events.software_request |=> sub_pending[REIA_SOFT_BIT]) else $error("soft not set");
  a_line_one:
    assert property (nvic_irq[1] == |(sub_pending & $past(sub_enable))) else $error("line one wrong");
  a_clear_drops:
    assert property (pending_clear[4] && !engine_events.packet_received |=> !sub_pending[4]) else $error("no clear");
  a_periph_map:
    assert property (nvic_irq[7:2] == $past(periph_lines)) else $error("periph lines wrong");
  a_diag_line:
    assert property (nvic_irq[8] == |($past(diag_events) & $past(diagnostic_event_select))) else $error("diag wrong");
  a_no_sleep_tick:
    assert property (s_asleep ##0 !sub_pending[2] |=> !sub_pending[2]) else $error("tick in sleep");
  a_wake_exit:
    assert property (s_woken |=> sub_pending[REIA_SLEEP_BIT]) else $error("no sleep exit");
endmodule
bind reia_aggregator reia_asserts u_asserts (.clk(clk), .reset_n(reset_n), .engine_events(engine_events),
  .sub_enable(sub_enable), .pending_clear(pending_clear), .periph_irq(periph_irq), .diag_events(diag_events),
  .diagnostic_event_select(diagnostic_event_select), .sub_pending(sub_pending), .radio_active(radio_active),
  .nvic_irq(nvic_irq));
`default_nettype wire

// ### dv/reia_nvic_model.sv
// Model of the processor interrupt controller that records each line seen raised.
`default_nettype none
module reia_nvic_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [reia_pkg::REIA_LINE_COUNT-1:0] nvic_irq,
  output logic [reia_pkg::REIA_LINE_COUNT-1:0] seen
);
  import reia_pkg::*;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seen <= '0;
    end else begin
      seen <= seen | nvic_irq;
    end
  end
endmodule
`default_nettype wire

// ### dv/tb.sv
// Self-checking testbench for the radio event interrupt aggregator.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import reia_pkg::*;
  logic clk, reset_n, sleep_request, wake_request, radio_active;
  reia_engine_events_t engine_events;
  reia_timer_cmd_t timer_cmd;
  reia_periph_irq_t periph_irq;
  logic [7:0] sub_enable, pending_clear, diag_events, diagnostic_event_select, sub_pending;
  logic [8:0] nvic_irq, seen;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  reia_aggregator DUT (.clk(clk), .reset_n(reset_n), .sleep_request(sleep_request), .wake_request(wake_request),
    .engine_events(engine_events), .timer_cmd(timer_cmd), .sub_enable(sub_enable), .pending_clear(pending_clear),
    .periph_irq(periph_irq), .diag_events(diag_events), .diagnostic_event_select(diagnostic_event_select),
    .sub_pending(sub_pending), .radio_active(radio_active), .nvic_irq(nvic_irq));
  reia_nvic_model u_nvic (.clk(clk), .reset_n(reset_n), .nvic_irq(nvic_irq), .seen(seen));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task automatic nx;
    @(negedge clk);
  endtask
  task automatic chk(input string name, input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic t_engine;
    int bit_of [5] = '{7, 6, 6, 5, 4};
    for (int i = 0; i < 5; i++) begin
      engine_events = 5'(1 << i);
      nx();
      engine_events = '0;
      chk("pending", 9'(sub_pending), 9'(1 << bit_of[i]));
      chk("line one", 9'(nvic_irq[1]), 9'h001);
      sub_enable = '0;
      nx();
      chk("masked", 9'(nvic_irq[1]), 9'h000);
      sub_enable = 8'hFF;
      pending_clear = 8'hFF;
      nx();
      pending_clear = '0;
      chk("cleared", {sub_pending, nvic_irq[1]}, 9'h000);
    end
  endtask
  task automatic t_periph;
    periph_irq = 6'h30;
    diag_events = 8'h5A;
    diagnostic_event_select = 8'hA5;
    nx();
    chk("lines", 9'(nvic_irq[8:2]), 9'h003);
    periph_irq = 6'h0F;
    diagnostic_event_select = 8'h0F;
    nx();
    chk("lines", 9'(nvic_irq[8:2]), 9'h07C);
    periph_irq = '0;
    diagnostic_event_select = '0;
  endtask
  task automatic t_sleep;
    sleep_request = 1;
    nx();
    sleep_request = 0;
    repeat (3) nx();
    chk("asleep", 9'(radio_active), 9'h000);
    wake_request = 1;
    nx();
    wake_request = 0;
    nx();
    chk("sleep exit", 9'(sub_pending), 9'h008);
    pending_clear = 8'h08;
    nx();
    pending_clear = '0;
  endtask
  task automatic t_timer;
    int n = 0;
    timer_cmd.fine_load = 1;
    timer_cmd.fine_units = 16'h0001;
    timer_cmd.gross_load = 1;
    timer_cmd.gross_units = 16'h0001;
    nx();
    timer_cmd = '0;
    while (sub_pending[0] !== 1'b1 && n < 80000) begin
      nx();
      n++;
    end
    chk("fine tick no gross", 9'(sub_pending & 8'h07), 9'h005);
  endtask
  initial begin
    reset_n = 0;
    {sleep_request, wake_request, engine_events, timer_cmd, pending_clear} = '0;
    {periph_irq, diag_events, diagnostic_event_select} = '0;
    sub_enable = 8'hFF;
    repeat (16) nx();
    reset_n = 1;
    nx();
    t_engine();
    t_periph();
    t_sleep();
    t_timer();
    chk("lines seen", seen, 9'h1FE);
    tally_and_finish();
  end
endmodule
`default_nettype wire
